// File: shared/isn_pkg.sv
package isn_pkg;

	// Timing
	localparam int CLK_MHZ = 250;
	localparam int TICK_CYC = CLK_MHZ;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
	localparam int T_INIT_MS = 35;
	localparam int T_INIT_US = T_INIT_MS * 1000;
	localparam int T_TELEM_MS = 90;
	localparam int T_TELEM_US = T_TELEM_MS * 1000;
	localparam int RISE_MIN_US = 250;
	localparam int RISE_MIN_CYC = RISE_MIN_US * CLK_MHZ;
	localparam logic [15:0] RISE_MIN = 16'(RISE_MIN_US);
	localparam int TMR_W = 17;

	// Die temperature thresholds, degrees C
	localparam logic signed [9:0] NVM_WP_SET_C = 10'sh082;
	localparam logic signed [9:0] NVM_WP_CLR_C = 10'sh07D;
	localparam logic signed [9:0] OT_SET_C = 10'sh0A0;
	localparam logic signed [9:0] OT_HYST_C = 10'sh00A;
	localparam logic signed [9:0] OT_CLR_C = OT_SET_C - OT_HYST_C;

	// Serial addresses
	localparam logic [6:0] ADDR_RECOVERY = 7'h7C;
	localparam logic [6:0] ADDR_GLOBAL0 = 7'h5A;
	localparam logic [6:0] ADDR_GLOBAL1 = 7'h5B;
	localparam logic [6:0] ADDR_DEFAULT = 7'h4F;

	// Configuration word bits
	localparam int GCFG_IGNORE_RCFG_BIT = 6;
	localparam int CCFG_SHARE_REQ_BIT = 2;

	// NVM image: config words, fault log, CRC in the last word
	localparam int NVM_DW = 16;
	localparam int NVM_AW = 6;
	localparam logic [5:0] NVM_LAST = 6'h3F;
	localparam logic [5:0] FLOG_BASE = 6'h30;
	localparam logic [5:0] FLOG_LAST = 6'h3E;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] CRC_POLY = 8'h07;

	typedef enum logic [3:0] {
		ST_LOCKOUT,
		ST_LOAD,
		ST_CRC_FAIL,
		ST_INIT_WAIT,
		ST_WAIT_VIN,
		ST_OFF,
		ST_DELAY,
		ST_RISE,
		ST_ON
	} isn_state_t;

	typedef struct packed {
		logic [15:0] ton_delay_us;
		logic [15:0] ton_rise_us;
		logic [15:0] ton_max_us;
		logic [11:0] vout_set;
	} isn_seq_cfg_t;

	typedef struct packed {
		logic cml_byte;
		logic cml_word;
		logic nvm_crc_err;
	} isn_status_t;

	typedef struct packed {
		logic run_oe;
		logic fault_oe;
		logic pgood_oe;
		logic alert_oe;
		logic share_oe;
	} isn_pins_t;

endpackage

// File: src/isn_crc8.sv
`timescale 1ns/10ps
module isn_crc8 #(
	parameter int DW = isn_pkg::NVM_DW
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Data stream
	input wire logic clr_i,
	input wire logic en_i,
	input wire logic [DW-1:0] data_i,
	// Result
	output logic [7:0] crc_o
);
	logic [7:0] crc_reg;
	logic [7:0] crc_next;
	logic fb;

	// MSB first, one word per cycle
	always_comb begin
		fb = 1'b0;
		crc_next = crc_reg;
		for (int i = DW - 1; i >= 0; i--) begin
			fb = crc_next[7] ^ data_i[i];
			crc_next = {crc_next[6:0], 1'b0} ^ (fb ? isn_pkg::CRC_POLY : 8'h00);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			crc_reg <= isn_pkg::CRC_INIT;
		end else if (clr_i) begin
			crc_reg <= isn_pkg::CRC_INIT;
		end else if (en_i) begin
			crc_reg <= crc_next;
		end
	end

	assign crc_o = crc_reg;
endmodule // isn_crc8

// File: src/isn_init_seq.sv
`timescale 1ns/10ps
module isn_init_seq #(
	parameter int INIT_US = isn_pkg::T_INIT_US,
	parameter int TELEM_US = isn_pkg::T_TELEM_US
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Init triggers
	input wire logic supply_lockout_i,
	input wire logic restore_all_i,
	input wire logic vendor_soft_reset_cmd_i,
	// NVM read port
	output logic nvm_rd_req_o,
	output logic [5:0] nvm_rd_addr_o,
	input wire logic nvm_rd_valid_i,
	input wire logic [15:0] nvm_rd_data_i,
	// NVM write port
	input wire logic host_wr_req_i,
	input wire logic [5:0] host_wr_addr_i,
	input wire logic flog_wr_req_i,
	input wire logic [5:0] flog_wr_addr_i,
	output logic nvm_wr_o,
	output logic [5:0] nvm_wr_addr_o,
	output logic nvm_wr_blocked_o,
	// Command register load
	output logic cfg_wr_o,
	output logic [5:0] cfg_addr_o,
	output logic [15:0] cfg_data_o,
	input wire logic rcfg_present_i,
	output logic rcfg_apply_o,
	// Configuration
	input wire logic [15:0] global_config_word_i,
	input wire logic [15:0] channel_config_word_i,
	input wire isn_pkg::isn_seq_cfg_t seq_cfg_i,
	input wire logic ccm_select_i,
	input wire logic on_cmd_i,
	// Serial address
	input wire logic [6:0] address_select_inputs_i,
	input wire logic asel_open_i,
	input wire logic bus_addr_valid_i,
	input wire logic [6:0] bus_addr_i,
	output logic addr_ack_o,
	// Analog monitors
	input wire logic signed [9:0] die_temp_i,
	input wire logic vin_above_on_i,
	input wire logic vout_above_uv_i,
	input wire logic iout_oc_i,
	// Shared wires, sampled levels
	input wire logic run_pin_i,
	input wire logic shared_timebase_pin_i,
	// Power stage and status
	output isn_pkg::isn_pins_t pins_o,
	output logic gate_hold_o,
	output logic pwm_hiz_o,
	output logic switch_en_o,
	output logic dcm_o,
	output logic [11:0] vout_target_o,
	output isn_pkg::isn_status_t status_o,
	output logic telem_valid_o,
	output logic init_done_o
);
	isn_pkg::isn_state_t state_reg, state_next;
	logic [7:0] pre_reg;
	logic [16:0] tmr_reg, telem_reg;
	logic [5:0] rd_addr_reg;
	logic rd_pend_reg, crc_fail_reg, wp_reg, ot_reg, share_hold_reg;
	logic [6:0] own_addr_reg;
	logic [17:0] err_reg;
	logic [11:0] target_reg;
	logic dcm_reg;
	logic [7:0] crc_val;

	wire tick = (pre_reg == isn_pkg::TICK_LAST);
	wire init_cmd = restore_all_i | vendor_soft_reset_cmd_i;
	wire load_start = (state_next == isn_pkg::ST_LOAD) &&
		((state_reg != isn_pkg::ST_LOAD) || init_cmd);
	wire in_load = (state_reg == isn_pkg::ST_LOAD);
	wire rd_issue = in_load && !rd_pend_reg && !load_start;
	wire rd_take = in_load && rd_pend_reg && nvm_rd_valid_i;
	wire rd_last = rd_take && (rd_addr_reg == isn_pkg::NVM_LAST);
	wire crc_ok = (crc_val == nvm_rd_data_i[7:0]);
	wire ign_rcfg = global_config_word_i[isn_pkg::GCFG_IGNORE_RCFG_BIT];
	wire share_req = channel_config_word_i[isn_pkg::CCFG_SHARE_REQ_BIT];
	wire share_ok = !share_req || shared_timebase_pin_i;
	wire keep_on = on_cmd_i && run_pin_i && share_ok;
	wire delay_done = (tmr_reg >= {1'b0, seq_cfg_i.ton_delay_us});
	wire rise_skip = (seq_cfg_i.ton_rise_us < isn_pkg::RISE_MIN);
	wire rise_done = (tmr_reg >= {1'b0, seq_cfg_i.ton_rise_us}) &&
		(target_reg == seq_cfg_i.vout_set);
	wire tmax_zero = (seq_cfg_i.ton_max_us == 16'h0000);
	wire tmax_hit = (tmr_reg >= {1'b0, seq_cfg_i.ton_max_us});
	wire mode_go = tmax_zero ? (vout_above_uv_i && !iout_oc_i) : tmax_hit;
	wire init_hold = (state_reg == isn_pkg::ST_LOCKOUT) || in_load ||
		(state_reg == isn_pkg::ST_CRC_FAIL) ||
		(state_reg == isn_pkg::ST_INIT_WAIT);
	wire running = (state_reg == isn_pkg::ST_RISE) ||
		(state_reg == isn_pkg::ST_ON);
	wire switch_next = running && !ot_reg;
	wire in_rise = (state_reg == isn_pkg::ST_RISE);
	wire step = in_rise && (err_reg >= {2'b00, seq_cfg_i.ton_rise_us}) &&
		(target_reg < seq_cfg_i.vout_set);
	wire [17:0] err_add = tick ? {6'h00, seq_cfg_i.vout_set} : 18'h00000;
	wire [17:0] err_sub = step ? {2'b00, seq_cfg_i.ton_rise_us} : 18'h00000;
	wire flog_ok = (flog_wr_addr_i >= isn_pkg::FLOG_BASE) &&
		(flog_wr_addr_i <= isn_pkg::FLOG_LAST);
	wire wr_next = !wp_reg && (host_wr_req_i || (flog_wr_req_i && flog_ok));
	wire is_glob = (bus_addr_i == isn_pkg::ADDR_GLOBAL0) ||
		(bus_addr_i == isn_pkg::ADDR_GLOBAL1);
	wire is_own = crc_fail_reg ? (bus_addr_i == isn_pkg::ADDR_RECOVERY) :
		(bus_addr_i == own_addr_reg);
	wire ack_next = bus_addr_valid_i && (is_glob || is_own);
	wire [6:0] asel_addr = asel_open_i ? isn_pkg::ADDR_DEFAULT :
		address_select_inputs_i;

	isn_crc8 #(
		.DW(isn_pkg::NVM_DW)
	) u_crc (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.clr_i(load_start),
		.en_i(rd_take && !rd_last),
		.data_i(nvm_rd_data_i),
		.crc_o(crc_val)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		isn_pkg::ST_LOCKOUT: begin
			if (!supply_lockout_i) state_next = isn_pkg::ST_LOAD;
		end
		isn_pkg::ST_LOAD: begin
			if (rd_last) begin
				state_next = crc_ok ? isn_pkg::ST_INIT_WAIT :
					isn_pkg::ST_CRC_FAIL;
			end
		end
		isn_pkg::ST_CRC_FAIL: begin
			state_next = isn_pkg::ST_CRC_FAIL;
		end
		isn_pkg::ST_INIT_WAIT: begin
			if (tmr_reg >= 17'(INIT_US)) state_next = isn_pkg::ST_WAIT_VIN;
		end
		isn_pkg::ST_WAIT_VIN: begin
			if (vin_above_on_i) state_next = isn_pkg::ST_OFF;
		end
		isn_pkg::ST_OFF: begin
			if (keep_on) state_next = isn_pkg::ST_DELAY;
		end
		isn_pkg::ST_DELAY: begin
			if (!keep_on) begin
				state_next = isn_pkg::ST_OFF;
			end else if (delay_done) begin
				state_next = rise_skip ? isn_pkg::ST_ON :
					isn_pkg::ST_RISE;
			end
		end
		isn_pkg::ST_RISE: begin
			if (!keep_on) begin
				state_next = isn_pkg::ST_OFF;
			end else if (rise_done) begin
				state_next = isn_pkg::ST_ON;
			end
		end
		isn_pkg::ST_ON: begin
			if (!keep_on) state_next = isn_pkg::ST_OFF;
		end
		default: state_next = isn_pkg::ST_LOCKOUT;
		endcase
		if (init_cmd) state_next = isn_pkg::ST_LOAD;
		if (supply_lockout_i) state_next = isn_pkg::ST_LOCKOUT;
	end

	// Sequencer, prescaler and timers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= isn_pkg::ST_LOCKOUT;
			pre_reg <= 8'h00;
			tmr_reg <= 17'h00000;
			telem_reg <= 17'h00000;
		end else begin
			state_reg <= state_next;
			pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
			if (load_start || (state_next != state_reg &&
				(state_next == isn_pkg::ST_DELAY ||
				state_next == isn_pkg::ST_RISE))) begin
				tmr_reg <= 17'h00000;
			end else if (tick && tmr_reg != 17'h1FFFF) begin
				tmr_reg <= tmr_reg + 17'h00001;
			end
			if (init_hold) begin
				telem_reg <= 17'h00000;
			end else if (tick && telem_reg != 17'h1FFFF) begin
				telem_reg <= telem_reg + 17'h00001;
			end
		end
	end

	// NVM image load and CRC verdict
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_addr_reg <= 6'h00;
			rd_pend_reg <= 1'b0;
			crc_fail_reg <= 1'b0;
		end else begin
			if (load_start) begin
				rd_addr_reg <= 6'h00;
			end else if (rd_take) begin
				rd_addr_reg <= rd_addr_reg + 6'h01;
			end
			if (load_start || rd_take) begin
				rd_pend_reg <= 1'b0;
			end else if (rd_issue) begin
				rd_pend_reg <= 1'b1;
			end
			if (rd_last && !crc_ok) begin
				crc_fail_reg <= 1'b1;
			end else if (load_start) begin
				crc_fail_reg <= 1'b0;
			end
		end
	end

	// Address is taken only when an init starts, never on the fly
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			own_addr_reg <= isn_pkg::ADDR_DEFAULT;
		end else if (load_start) begin
			own_addr_reg <= asel_addr;
		end
	end

	// Temperature hysteresis
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_reg <= 1'b0;
			ot_reg <= 1'b0;
		end else begin
			if (die_temp_i > isn_pkg::NVM_WP_SET_C) begin
				wp_reg <= 1'b1;
			end else if (die_temp_i < isn_pkg::NVM_WP_CLR_C) begin
				wp_reg <= 1'b0;
			end
			if (die_temp_i > isn_pkg::OT_SET_C) begin
				ot_reg <= 1'b1;
			end else if (die_temp_i < isn_pkg::OT_CLR_C) begin
				ot_reg <= 1'b0;
			end
		end
	end

	// Ramp accumulator: never steps down, so the target stays monotonic
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			err_reg <= 18'h00000;
			target_reg <= 12'h000;
			dcm_reg <= 1'b1;
		end else begin
			err_reg <= in_rise ? err_reg + err_add - err_sub : 18'h00000;
			if (in_rise) begin
				target_reg <= target_reg + {11'h000, step};
			end else if (state_reg == isn_pkg::ST_ON) begin
				target_reg <= seq_cfg_i.vout_set;
			end else begin
				target_reg <= 12'h000;
			end
			if (state_reg != isn_pkg::ST_ON) begin
				dcm_reg <= 1'b1;
			end else if (mode_go) begin
				dcm_reg <= !ccm_select_i;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			share_hold_reg <= 1'b1;
			pins_o <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
			gate_hold_o <= 1'b1;
			pwm_hiz_o <= 1'b1;
			switch_en_o <= 1'b0;
			nvm_rd_req_o <= 1'b0;
			nvm_wr_o <= 1'b0;
			nvm_wr_addr_o <= 6'h00;
			cfg_wr_o <= 1'b0;
			cfg_addr_o <= 6'h00;
			cfg_data_o <= 16'h0000;
			rcfg_apply_o <= 1'b0;
			addr_ack_o <= 1'b0;
			status_o <= '0;
			telem_valid_o <= 1'b0;
			init_done_o <= 1'b0;
		end else begin
			if (state_reg == isn_pkg::ST_WAIT_VIN) share_hold_reg <= 1'b0;
			pins_o.run_oe <= init_hold ||
				(state_reg == isn_pkg::ST_WAIT_VIN);
			pins_o.fault_oe <= init_hold;
			pins_o.pgood_oe <= !((state_reg == isn_pkg::ST_ON) &&
				vout_above_uv_i);
			pins_o.alert_oe <= crc_fail_reg;
			pins_o.share_oe <= share_hold_reg;
			gate_hold_o <= init_hold || !switch_next;
			pwm_hiz_o <= init_hold || !switch_next;
			switch_en_o <= switch_next;
			nvm_rd_req_o <= rd_issue;
			nvm_wr_o <= wr_next;
			nvm_wr_addr_o <= host_wr_req_i ? host_wr_addr_i : flog_wr_addr_i;
			cfg_wr_o <= rd_take && (rd_addr_reg < isn_pkg::FLOG_BASE);
			cfg_addr_o <= rd_addr_reg;
			cfg_data_o <= nvm_rd_data_i;
			rcfg_apply_o <= rd_last && crc_ok && rcfg_present_i &&
				!ign_rcfg;
			addr_ack_o <= ack_next;
			status_o <= '{crc_fail_reg, crc_fail_reg, crc_fail_reg};
			telem_valid_o <= !init_hold && (telem_reg >= 17'(TELEM_US));
			init_done_o <= !init_hold;
		end
	end

	assign nvm_rd_addr_o = rd_addr_reg;
	assign nvm_wr_blocked_o = wp_reg;
	assign dcm_o = dcm_reg;
	assign vout_target_o = target_reg;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_nvm_wr_block: assert property (
		$past(die_temp_i, 2) > isn_pkg::NVM_WP_SET_C |-> !nvm_wr_o)
		else $error("nvm write while hot");
	a_ot_no_switch: assert property (
		$past(die_temp_i, 2) > isn_pkg::OT_SET_C |-> !switch_en_o)
		else $error("switching above overtemperature");
	a_flog_region: assert property (
		nvm_wr_o && !$past(host_wr_req_i) |->
		nvm_wr_addr_o >= isn_pkg::FLOG_BASE &&
		nvm_wr_addr_o <= isn_pkg::FLOG_LAST)
		else $error("fault log write outside its region");
	a_crc_fail_flags: assert property (
		$rose(crc_fail_reg) |=> status_o.cml_byte && status_o.cml_word &&
		status_o.nvm_crc_err && pins_o.alert_oe && pins_o.run_oe)
		else $error("crc failure not reported");
	a_recovery_addr: assert property (
		bus_addr_valid_i && bus_addr_i == isn_pkg::ADDR_RECOVERY &&
		own_addr_reg != isn_pkg::ADDR_RECOVERY |=>
		addr_ack_o == $past(crc_fail_reg))
		else $error("recovery address misused");
	a_global_addr: assert property (
		bus_addr_valid_i && is_glob |=> addr_ack_o)
		else $error("global address not answered");
	a_init_trigger: assert property (
		init_cmd && !supply_lockout_i |=> state_reg == isn_pkg::ST_LOAD)
		else $error("init command ignored");
	a_init_hold: assert property (
		in_load ##1 in_load |-> pins_o.run_oe && pins_o.fault_oe &&
		pins_o.pgood_oe && gate_hold_o && pwm_hiz_o)
		else $error("pins not held during init");
	a_rcfg_ignore: assert property (
		rcfg_apply_o |-> $past(rcfg_present_i && !ign_rcfg))
		else $error("resistors applied when ignored");
	a_run_release: assert property (
		$fell(pins_o.run_oe) |-> $past(vin_above_on_i, 2) &&
		$past(state_reg, 2) == isn_pkg::ST_WAIT_VIN)
		else $error("run released early");
	a_share_release: assert property (
		$fell(pins_o.share_oe) |-> $past(state_reg, 2) ==
		isn_pkg::ST_WAIT_VIN)
		else $error("timebase released before init done");
	a_timebase_off: assert property (
		share_req && !shared_timebase_pin_i && running && !init_cmd &&
		!supply_lockout_i |=> state_reg == isn_pkg::ST_OFF)
		else $error("no turn off on low timebase");
	a_ramp_mono: assert property (
		in_rise ##1 in_rise |-> vout_target_o >= $past(vout_target_o))
		else $error("ramp not monotonic");
	a_rise_skip: assert property (
		state_reg == isn_pkg::ST_DELAY && state_next != isn_pkg::ST_DELAY &&
		rise_skip && keep_on |=> state_reg == isn_pkg::ST_ON)
		else $error("short rise not skipped");
	a_rise_dcm: assert property (
		in_rise |-> dcm_o)
		else $error("continuous mode during rise");
	a_mode_handover: assert property (
		state_reg == isn_pkg::ST_ON && tmax_zero && ccm_select_i &&
		vout_above_uv_i && !iout_oc_i ##1 state_reg == isn_pkg::ST_ON
		|-> !dcm_o)
		else $error("no handover to continuous mode");

	c_crc_fail: cover property (rd_last && !crc_ok);
	c_ramp_done: cover property (in_rise ##1 state_reg == isn_pkg::ST_ON);
	c_ccm: cover property ($fell(dcm_o));
	c_wp: cover property ($rose(wp_reg));
endmodule // isn_init_seq

// File: tb/isn_nvm_model.sv
`timescale 1ns/10ps
module isn_nvm_model (
	// Clock
	input wire logic core_clk_i,
	// Read port
	input wire logic rd_req_i,
	input wire logic [5:0] rd_addr_i,
	output logic rd_valid_o,
	output logic [15:0] rd_data_o,
	// Behaviour
	input wire logic [1:0] lat_i,
	input wire logic corrupt_i
);
	logic [15:0] mem [64];
	logic [7:0] crc;
	logic flip;

	assign flip = corrupt_i && rd_addr_i == 6'h3F;

	initial begin
		crc = 8'h00;
		for (int i = 0; i < 63; i++) begin
			mem[i] = 16'(i * 16'h1357) ^ 16'hA5C3;
			for (int b = 15; b >= 0; b--) begin
				crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ mem[i][b]) ? 8'h07 : 8'h00);
			end
		end
		mem[63] = {8'h00, crc};
		rd_valid_o = 1'b0;
		rd_data_o = 16'h0000;
	end

	// Released data shows the inverse, so a stale capture cannot pass
	// Look just after the edge, once the request launched on it has settled
	always begin
		@(posedge core_clk_i);
		#1;
		if (rd_req_i === 1'b1) begin
			repeat (lat_i) @(posedge core_clk_i);
			#1;
			rd_valid_o = 1'b1;
			rd_data_o = mem[rd_addr_i] ^ {15'h0000, flip};
			@(posedge core_clk_i);
			#1;
			rd_valid_o = 1'b0;
			rd_data_o = ~rd_data_o;
		end
	end
endmodule // isn_nvm_model

// File: tb/tb_isn_init_seq.sv
`timescale 1ns/10ps
module tb_isn_init_seq;
	logic core_clk_i, rst_n_i, supply_lockout_i, restore_all_i;
	logic vendor_soft_reset_cmd_i, nvm_rd_req_o, nvm_rd_valid_i, nvm_wr_o;
	logic nvm_wr_blocked_o, host_wr_req_i, flog_wr_req_i, rcfg_present_i;
	logic ccm_select_i, on_cmd_i, asel_open_i, bus_addr_valid_i, addr_ack_o;
	logic vin_above_on_i, vout_above_uv_i, iout_oc_i, run_pin_i;
	logic shared_timebase_pin_i, gate_hold_o, pwm_hiz_o, switch_en_o, dcm_o;
	logic telem_valid_o, init_done_o, corrupt, peer_run, peer_tb;
	logic [5:0] nvm_rd_addr_o, host_wr_addr_i, flog_wr_addr_i, nvm_wr_addr_o;
	logic [15:0] nvm_rd_data_i, global_config_word_i, channel_config_word_i;
	logic [6:0] address_select_inputs_i, bus_addr_i, own;
	logic signed [9:0] die_temp_i;
	logic [11:0] vout_target_o, prev;
	logic [1:0] lat;
	logic [31:0] seed;
	logic [2:0] watch;
	isn_pkg::isn_seq_cfg_t seq_cfg_i;
	isn_pkg::isn_pins_t pins_o;
	isn_pkg::isn_status_t status_o;
	int bad_count, num_checks, n;

	// Open-drain wires: any party pulling low wins
	assign run_pin_i = peer_run && !pins_o.run_oe;
	assign shared_timebase_pin_i = peer_tb && !pins_o.share_oe;
	assign watch[0] = init_done_o === 1'b1;
	assign watch[1] = status_o.nvm_crc_err === 1'b1;
	assign watch[2] = status_o.nvm_crc_err === 1'b0;

	isn_init_seq #(.INIT_US(20), .TELEM_US(30)) dut_u (
		.core_clk_i, .rst_n_i, .supply_lockout_i, .restore_all_i,
		.vendor_soft_reset_cmd_i, .nvm_rd_req_o, .nvm_rd_addr_o,
		.nvm_rd_valid_i, .nvm_rd_data_i, .host_wr_req_i, .host_wr_addr_i,
		.flog_wr_req_i, .flog_wr_addr_i, .nvm_wr_o, .nvm_wr_addr_o,
		.nvm_wr_blocked_o, .cfg_wr_o(), .cfg_addr_o(), .cfg_data_o(),
		.rcfg_present_i, .rcfg_apply_o(), .global_config_word_i,
		.channel_config_word_i, .seq_cfg_i, .ccm_select_i, .on_cmd_i,
		.address_select_inputs_i, .asel_open_i, .bus_addr_valid_i,
		.bus_addr_i, .addr_ack_o, .die_temp_i, .vin_above_on_i,
		.vout_above_uv_i, .iout_oc_i, .run_pin_i, .shared_timebase_pin_i,
		.pins_o, .gate_hold_o, .pwm_hiz_o, .switch_en_o, .dcm_o,
		.vout_target_o, .status_o, .telem_valid_o, .init_done_o
	);

	isn_nvm_model nvm_u (
		.core_clk_i, .rd_req_i(nvm_rd_req_o), .rd_addr_i(nvm_rd_addr_o),
		.rd_valid_o(nvm_rd_valid_i), .rd_data_o(nvm_rd_data_i),
		.lat_i(lat), .corrupt_i(corrupt)
	);

	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic exp_ack(input logic [6:0] a, input logic fail);
		logic glob;
		glob = a == isn_pkg::ADDR_GLOBAL0 || a == isn_pkg::ADDR_GLOBAL1;
		return glob || (fail ? a == isn_pkg::ADDR_RECOVERY : a == own);
	endfunction

	task results;
		if (bad_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task chk(input logic [15:0] exp, input logic [15:0] got, input string nm);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask

	task cyc(input int k);
		repeat (k) @(negedge core_clk_i);
	endtask

	task wait_for(input int sel, input int lim);
		for (int i = 0; i < lim; i++) begin
			if (watch[sel]) return;
			cyc(1);
		end
		$display("wrong value wait %0d expected 1 seen 0", sel);
		bad_count++;
		results();
	endtask

	// Answer may land one or two edges after the address is taken
	task bus(input logic [6:0] a, input logic fail);
		logic seen;
		bus_addr_i = a;
		bus_addr_valid_i = 1'b1;
		cyc(1);
		bus_addr_valid_i = 1'b0;
		seen = addr_ack_o;
		cyc(1);
		seen = seen | addr_ack_o;
		chk(exp_ack(a, fail), seen, "addr_ack");
	endtask

	task wr(input logic host, input logic [5:0] a, input logic exp);
		logic seen;
		host_wr_req_i = host;
		flog_wr_req_i = !host;
		host_wr_addr_i = a;
		flog_wr_addr_i = a;
		cyc(1);
		{host_wr_req_i, flog_wr_req_i} = 2'b00;
		seen = nvm_wr_o;
		cyc(1);
		seen = seen | nvm_wr_o;
		chk(exp, seen, "nvm_wr");
		if (exp) chk(a, nvm_wr_addr_o, "nvm_wr_addr");
	endtask

	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	initial begin
		{rst_n_i, restore_all_i, vendor_soft_reset_cmd_i, host_wr_req_i,
			flog_wr_req_i, rcfg_present_i, on_cmd_i, asel_open_i,
			bus_addr_valid_i, vin_above_on_i, vout_above_uv_i, iout_oc_i,
			corrupt} = '0;
		{supply_lockout_i, peer_run, peer_tb, ccm_select_i} = '1;
		{host_wr_addr_i, flog_wr_addr_i, bus_addr_i} = '0;
		bad_count = 0;
		num_checks = 0;
		die_temp_i = 10'sd25;
		global_config_word_i = 16'h0040;
		channel_config_word_i = 16'h0004;
		seq_cfg_i = '{ton_delay_us: 16'h0002, ton_rise_us: 16'h00FA,
			ton_max_us: 16'h0000, vout_set: 12'h020};
		seed = nxt(32'h6F1EFEC9);
		lat = seed[1:0];
		own = {2'b01, seed[6:2]};
		address_select_inputs_i = own;
		cyc(5);
		rst_n_i = 1'b1;
		chk(5'h1F, {pins_o.run_oe, pins_o.fault_oe, pins_o.pgood_oe,
			gate_hold_o, pwm_hiz_o}, "hold");
		supply_lockout_i = 1'b0;
		cyc(50);
		chk(6'h3F, {pins_o.run_oe, pins_o.fault_oe, pins_o.pgood_oe,
			gate_hold_o, pwm_hiz_o, pins_o.share_oe}, "hold_load");
		wait_for(0, 20000);
		chk(3'h0, status_o, "status");
		cyc(10);
		// Timebase is freed once init is done, run waits for the input
		chk(3'h4, {pins_o.run_oe, pins_o.share_oe, telem_valid_o}, "pre_vin");
		vin_above_on_i = 1'b1;
		cyc(3);
		chk(2'h0, {pins_o.run_oe, pins_o.share_oe}, "release");
		bus(own, 1'b0);
		bus(7'h7C, 1'b0);
		bus(7'h5A, 1'b0);
		bus(7'h5B, 1'b0);
		for (int i = 0; i < 8; i++) begin
			seed = nxt(seed);
			bus(seed[6:0], 1'b0);
		end
		wr(1'b1, seed[5:0], 1'b1);
		wr(1'b0, 6'h2F, 1'b0);
		wr(1'b0, 6'h30, 1'b1);
		wr(1'b0, 6'h3E, 1'b1);
		wr(1'b0, 6'h3F, 1'b0);
		die_temp_i = 10'sd131;
		cyc(3);
		wr(1'b1, 6'h05, 1'b0);
		die_temp_i = 10'sd125;
		cyc(3);
		chk(1'b1, nvm_wr_blocked_o, "wp_hyst");
		die_temp_i = 10'sd124;
		cyc(3);
		wr(1'b1, 6'h05, 1'b1);
		on_cmd_i = 1'b1;
		cyc(100);
		chk(13'h0, {switch_en_o, vout_target_o}, "delay");
		prev = 12'h000;
		for (n = 0; n < 70000 && vout_target_o !== 12'h020; n++) begin
			chk(1'b1, vout_target_o >= prev && dcm_o === 1'b1, "ramp");
			prev = vout_target_o;
			cyc(1);
		end
		chk(1'b1, n > 40000 && n < 70000, "rise_len");
		cyc(5);
		chk(1'b1, dcm_o, "dcm_uv");
		{vout_above_uv_i, iout_oc_i} = 2'b11;
		cyc(5);
		chk(1'b1, dcm_o, "dcm_oc");
		iout_oc_i = 1'b0;
		cyc(3);
		chk(1'b0, dcm_o, "ccm");
		die_temp_i = 10'sd161;
		cyc(3);
		chk(1'b0, switch_en_o, "ot_set");
		die_temp_i = 10'sd150;
		cyc(3);
		chk(1'b0, switch_en_o, "ot_hyst");
		die_temp_i = 10'sd149;
		cyc(3);
		chk(1'b1, switch_en_o, "ot_clr");
		peer_tb = 1'b0;
		cyc(3);
		chk(1'b0, switch_en_o, "tb_low");
		seq_cfg_i.ton_rise_us = 16'h00F9;
		peer_tb = 1'b1;
		cyc(700);
		chk(13'h1020, {switch_en_o, vout_target_o}, "no_ramp");
		chk(1'b1, telem_valid_o, "telem");
		seed = nxt(seed);
		lat = seed[1:0];
		corrupt = 1'b1;
		restore_all_i = 1'b1;
		cyc(1);
		restore_all_i = 1'b0;
		wait_for(1, 2000);
		cyc(2);
		chk(6'h3E, {status_o, pins_o.alert_oe, pins_o.run_oe, switch_en_o},
			"crc_fail");
		bus(7'h7C, 1'b1);
		bus(own, 1'b1);
		bus(7'h5A, 1'b1);
		corrupt = 1'b0;
		vendor_soft_reset_cmd_i = 1'b1;
		cyc(1);
		vendor_soft_reset_cmd_i = 1'b0;
		wait_for(2, 2000);
		cyc(1000);
		chk(3'h0, status_o, "status_ok");
		bus(7'h7C, 1'b0);
		results();
	end
endmodule // tb_isn_init_seq
